// ### logic/pho_defines.svh
/*
 Register indexes, byte addresses, field positions, reset values and
 lock detect counts for the PLL holdover controller.
 Assumes an APB slave with 32-bit words, one register per word.
*/
`ifndef PHO_DEFINES_SVH
`define PHO_DEFINES_SVH

// ==========================================================
// Register indexes and byte addresses (index times four)
// ==========================================================
`define PHO_IDX_LDC        8'h18
`define PHO_IDX_LPS        8'h1a
`define PHO_IDX_RSC        8'h1c
`define PHO_IDX_HOC        8'h1d
`define PHO_IDX_STS        8'h1e
`define PHO_ADDR_LDC       8'h60
`define PHO_ADDR_LPS       8'h68
`define PHO_ADDR_RSC       8'h70
`define PHO_ADDR_HOC       8'h74
`define PHO_ADDR_STS       8'h78

// ==========================================================
// Reset values
// ==========================================================
`define PHO_RST_LDC        8'h00
`define PHO_RST_LPS        6'h00
`define PHO_RST_RSC        8'h00
`define PHO_RST_HOC        8'h00

// ==========================================================
// Field positions
// ==========================================================
`define PHO_LDC_CAL_BIT    0
`define PHO_LDC_DLD_OFF    3
`define PHO_LDC_WIN_BIT    4
`define PHO_LDC_CNT_LO     5
`define PHO_LDC_CNT_HI     6
`define PHO_RSC_BUF_LO     1
`define PHO_RSC_BUF_HI     2
`define PHO_RSC_PREF_BIT   3
`define PHO_RSC_AUTO_BIT   4
`define PHO_HOC_EN_A       0
`define PHO_HOC_EXT_BIT    1
`define PHO_HOC_EN_B       2
`define PHO_HOC_CMP_BIT    3

// ==========================================================
// Lock pin select codes and lock detect counts
// ==========================================================
`define PHO_LPS_DLD        6'h01
`define PHO_LPS_CSRC       6'h04
`define PHO_LOCK_CNT_0     8'd5
`define PHO_LOCK_CNT_1     8'd16
`define PHO_LOCK_CNT_2     8'd64
`define PHO_LOCK_CNT_3     8'd255

`endif

// ### logic/pho_pkg.sv
/*
 Types shared by the PLL holdover controller.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package pho_pkg;

  // ========================================================
  // Holdover state, Gray coded along idle, hold, rearm
  // ========================================================
  typedef enum logic [1:0] {
    PHO_IDLE  = 2'b00,
    PHO_HOLD  = 2'b01,
    PHO_REARM = 2'b11
  } pho_state_t;

endpackage

// ### logic/pho_sync.sv
/*
 Two-flop synchroniser, one pair of flops per bit.
 Assumes the inputs may change at any time relative to ref_clk.
*/
`timescale 1ns/1ns
module pho_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;

  // ========================================================
  // Per-bit flop pairs
  // ========================================================
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        stage1[i]  <= 1'b1;
        syncOut[i] <= 1'b1;
      end else begin
        stage1[i]  <= asyncIn[i];
        syncOut[i] <= stage1[i];
      end
    end
  end

endmodule

// ### logic/pho_holdover_ctrl.sv
/*
 PLL charge pump holdover controller with digital lock detect, lock
 pin driver and an APB register slave.
 Assumes PFD events arrive as one-cycle pulses synchronous to ref_clk
 and that the comparator level and alignment pin may be asynchronous.
*/
// Register access over APB is this design's own decision.
// What this block does
// - Holdover floats the pump output, driving neither up nor down.
// - Holdover works only with both enable bits set.
// - Clearing the enable bits stops manual and automatic holdover at once.
// - Falling alignment pin edge enters holdover at once, edge not level.
// - Release only on a reference PFD edge after the pin is high.
// - The releasing PFD event also resets the B counter, not prescaler.
// - Automatic holdover enters when the lock level shows loss of lock.
// - Comparator disabled makes the lock level read permanently high.
// - Automatic holdover stays floating while no reference edge arrives.
// - No re-trigger until lock reacquired and the lock pin recharged.
// - Holdover follows the selected reference; switchover loss is brief.
// - Two-bit counter field sets consecutive cycles to lock; 00 means five.
// - Window bit zero selects the high-range lock window.
// - Lock pin select code 000100 routes current-source lock detect.
// - External control bit: one is manual, zero is automatic holdover.
// - Reference select bits set auto switchover, preference, buffers.
// - Lock after consecutive in-window cycles; drop on one wide cycle.
// - Current-source mode sources while locked, shorts when unlocked.
`timescale 1ns/1ns
`include "pho_defines.svh"
module pho_holdover_ctrl
  import pho_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]     prdata,
  output logic            pready,
  output logic            pslverr,
  input  wire logic       alignPin_n,
  input  wire logic       lockCmpLevel,
  input  wire logic       pfdRefEdge,
  input  wire logic       pfdCycle,
  input  wire logic       phaseInLock,
  input  wire logic       phaseOverUnlock,
  input  wire logic       secondRefActive,
  output logic            pumpOutputHiZ,
  output logic            bCounterReset,
  output logic            digitalLockFlag,
  output logic            lockIndicatorPinOut,
  output logic            lockIndicatorPinOe,
  output logic            lockIndicatorPinSrc,
  output logic            lockWindowHigh,
  output logic            autoSwitchEn,
  output logic            preferSecondRef,
  output logic [1:0]      refBufferEn,
  output logic            vcoCalStart
);

  // ========================================================
  // Registers and internal signals
  // ========================================================
  logic [7:0] lockDetCtl;
  logic [5:0] lockPinSel;
  logic [7:0] refSelCtl;
  logic [7:0] holdCtl;
  pho_state_t state;
  logic [1:0] syncIn;
  logic [1:0] syncOut;
  logic       alignSync;
  logic       cmpSync;
  logic       alignPrev;
  logic       alignFell;
  logic       holdEn;
  logic       extMode;
  logic       cmpEn;
  logic       lockLevel;
  logic       dldOff;
  logic [7:0] lockNeed;
  logic [7:0] lockCnt;
  logic       apbWrite;
  logic       apbSetup;
  logic       addrHit;
  logic [31:0] next_prdata;

  // ========================================================
  // Synchronisers for the comparator level and alignment pin
  // ========================================================
  assign syncIn = {lockCmpLevel, alignPin_n};

  pho_sync #(
    .WIDTH (2)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .asyncIn (syncIn),
    .syncOut (syncOut)
  );

  assign alignSync = syncOut[0];
  assign cmpSync   = syncOut[1];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alignPrev <= 1'b1;
    end else begin
      alignPrev <= alignSync;
    end
  end

  // Only the high-to-low transition counts, never the held low.
  assign alignFell = alignPrev & ~alignSync;

  // ========================================================
  // Control decode
  // ========================================================
  assign holdEn  = holdCtl[`PHO_HOC_EN_A] &
                   holdCtl[`PHO_HOC_EN_B];
  assign extMode = holdCtl[`PHO_HOC_EXT_BIT];
  assign cmpEn   = holdCtl[`PHO_HOC_CMP_BIT];
  assign dldOff  = lockDetCtl[`PHO_LDC_DLD_OFF];

  // A disabled comparator reads as locked, so it never triggers.
  assign lockLevel = cmpEn ? cmpSync : 1'b1;

  always_comb begin
    case (lockDetCtl[`PHO_LDC_CNT_HI:`PHO_LDC_CNT_LO])
      2'b00:   lockNeed = `PHO_LOCK_CNT_0;
      2'b01:   lockNeed = `PHO_LOCK_CNT_1;
      2'b10:   lockNeed = `PHO_LOCK_CNT_2;
      default: lockNeed = `PHO_LOCK_CNT_3;
    endcase
  end

  // ========================================================
  // Digital lock detect
  // ========================================================
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lockCnt         <= 8'h00;
      digitalLockFlag <= 1'b0;
    end else if (dldOff) begin
      lockCnt         <= 8'h00;
      digitalLockFlag <= 1'b0;
    end else if (pfdCycle) begin
      if (phaseOverUnlock) begin
        lockCnt         <= 8'h00;
        digitalLockFlag <= 1'b0;
      end else if (phaseInLock) begin
        if (lockCnt + 8'h01 >= lockNeed) begin
          digitalLockFlag <= 1'b1;
        end
        if (lockCnt != 8'hff) begin
          lockCnt <= lockCnt + 8'h01;
        end
      end else begin
        // Between thresholds: lock held, run of good cycles broken.
        lockCnt <= 8'h00;
      end
    end
  end

  // ========================================================
  // Lock indicator pin driver
  // ========================================================
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lockIndicatorPinOut <= 1'b0;
      lockIndicatorPinOe  <= 1'b0;
      lockIndicatorPinSrc <= 1'b0;
    end else if (lockPinSel == `PHO_LPS_CSRC) begin
      // Current source charges the cap; unlock discharges it hard.
      lockIndicatorPinOut <= 1'b0;
      lockIndicatorPinOe  <= ~digitalLockFlag;
      lockIndicatorPinSrc <= digitalLockFlag;
    end else if (lockPinSel == `PHO_LPS_DLD) begin
      lockIndicatorPinOut <= digitalLockFlag;
      lockIndicatorPinOe  <= 1'b1;
      lockIndicatorPinSrc <= 1'b0;
    end else begin
      lockIndicatorPinOut <= 1'b0;
      lockIndicatorPinOe  <= 1'b0;
      lockIndicatorPinSrc <= 1'b0;
    end
  end

  // ========================================================
  // Holdover state machine
  // ========================================================
  // The reference edge input follows the selected reference only, so a
  // switchover loss of lock floats the pump until its next edge.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state         <= PHO_IDLE;
      pumpOutputHiZ <= 1'b0;
      bCounterReset <= 1'b0;
    end else if (!holdEn) begin
      state         <= PHO_IDLE;
      pumpOutputHiZ <= 1'b0;
      bCounterReset <= 1'b0;
    end else begin
      bCounterReset <= 1'b0;
      case (state)
        PHO_IDLE: begin
          if ((extMode && alignFell) ||
              (!extMode && !lockLevel)) begin
            state         <= PHO_HOLD;
            pumpOutputHiZ <= 1'b1;
          end
        end
        PHO_HOLD: begin
          // No reference edge means the pump stays floating.
          if (pfdRefEdge && (!extMode || alignSync)) begin
            state         <= extMode ? PHO_IDLE : PHO_REARM;
            pumpOutputHiZ <= 1'b0;
            bCounterReset <= 1'b1;
          end
        end
        PHO_REARM: begin
          if (extMode && alignFell) begin
            state         <= PHO_HOLD;
            pumpOutputHiZ <= 1'b1;
          end else if (extMode ||
                       (digitalLockFlag && lockLevel)) begin
            state <= PHO_IDLE;
          end
        end
        default: begin
          state         <= PHO_IDLE;
          pumpOutputHiZ <= 1'b0;
        end
      endcase
    end
  end

  // ========================================================
  // Register field outputs
  // ========================================================
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lockWindowHigh  <= 1'b1;
      autoSwitchEn    <= 1'b0;
      preferSecondRef <= 1'b0;
      refBufferEn     <= 2'b00;
      vcoCalStart     <= 1'b0;
    end else begin
      lockWindowHigh  <= ~lockDetCtl[`PHO_LDC_WIN_BIT];
      autoSwitchEn    <= refSelCtl[`PHO_RSC_AUTO_BIT];
      preferSecondRef <= refSelCtl[`PHO_RSC_PREF_BIT];
      refBufferEn     <=
        refSelCtl[`PHO_RSC_BUF_HI:`PHO_RSC_BUF_LO];
      vcoCalStart     <= lockDetCtl[`PHO_LDC_CAL_BIT];
    end
  end

  // ========================================================
  // APB slave
  // ========================================================
  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pready & pwrite;
  assign addrHit  = (paddr == `PHO_ADDR_LDC) ||
                    (paddr == `PHO_ADDR_LPS) ||
                    (paddr == `PHO_ADDR_RSC) ||
                    (paddr == `PHO_ADDR_HOC) ||
                    (paddr == `PHO_ADDR_STS);

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `PHO_ADDR_LDC: next_prdata[7:0] = lockDetCtl;
      `PHO_ADDR_LPS: next_prdata[5:0] = lockPinSel;
      `PHO_ADDR_RSC: next_prdata[7:0] = refSelCtl;
      `PHO_ADDR_HOC: next_prdata[7:0] = holdCtl;
      `PHO_ADDR_STS: next_prdata[6:0] = {secondRefActive, state,
                                         lockLevel, digitalLockFlag,
                                         bCounterReset, pumpOutputHiZ};
      default:       next_prdata = 32'h0000_0000;
    endcase
  end

  // Ready rises one cycle after setup: every transfer has one wait-free
  // access cycle and may be followed by a setup at once.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apbSetup;
      pslverr <= apbSetup & ~addrHit;
      if (apbSetup && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lockDetCtl <= `PHO_RST_LDC;
      lockPinSel <= `PHO_RST_LPS;
      refSelCtl  <= `PHO_RST_RSC;
      holdCtl    <= `PHO_RST_HOC;
    end else if (apbWrite) begin
      case (paddr)
        `PHO_ADDR_LDC: lockDetCtl <= pwdata[7:0];
        `PHO_ADDR_LPS: lockPinSel <= pwdata[5:0];
        `PHO_ADDR_RSC: refSelCtl  <= pwdata[7:0];
        `PHO_ADDR_HOC: holdCtl    <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // ========================================================
  // Assertions
  // ========================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_manual_release;
    holdEn && extMode && state == PHO_HOLD && alignSync && pfdRefEdge;
  endsequence

  sequence s_released;
    !pumpOutputHiZ && bCounterReset;
  endsequence

  a_hold_disabled: assert property (
    !holdEn |=> !pumpOutputHiZ && state == PHO_IDLE)
    else $error("pump floats while holdover is disabled");

  a_manual_entry: assert property (
    holdEn && extMode && state == PHO_IDLE && alignFell
    |=> pumpOutputHiZ)
    else $error("alignment pin fall did not float the pump");

  a_manual_release: assert property (
    s_manual_release |=> s_released)
    else $error("manual release missed the reference edge");

  a_breset_edge: assert property (
    bCounterReset |-> $past(pfdRefEdge) && $fell(pumpOutputHiZ))
    else $error("B counter reset without a pump release");

  a_hold_noref: assert property (
    holdEn && $stable(holdCtl) && pumpOutputHiZ && !pfdRefEdge
    |=> pumpOutputHiZ)
    else $error("pump released without a reference edge");

  a_auto_entry: assert property (
    holdEn && !extMode && state == PHO_IDLE && !lockLevel
    |=> pumpOutputHiZ ##1 pumpOutputHiZ || bCounterReset
        || !holdEn)
    else $error("lock loss did not enter automatic holdover");

  a_cmp_off: assert property (
    !cmpEn |-> lockLevel)
    else $error("disabled comparator does not read high");

  a_rearm_wait: assert property (
    holdEn && !extMode && state == PHO_REARM
    && !(digitalLockFlag && lockLevel) |=> !pumpOutputHiZ)
    else $error("holdover re-triggered before lock returned");

  a_lock_drop: assert property (
    !dldOff && pfdCycle && phaseOverUnlock |=> !digitalLockFlag)
    else $error("wide phase error did not drop lock");

  a_csrc_pin: assert property (
    lockPinSel == `PHO_LPS_CSRC && $stable(lockPinSel)
    |=> lockIndicatorPinSrc == $past(digitalLockFlag)
        && lockIndicatorPinOe == !$past(digitalLockFlag))
    else $error("current-source lock pin drive is wrong");

  a_window_sel: assert property (
    !lockDetCtl[`PHO_LDC_WIN_BIT] |=> lockWindowHigh)
    else $error("window bit zero did not pick the high range");

endmodule

// ### sim/pho_far_model.sv
/*
 Far-side model: reference path phase detector pulses and the lock
 pin capacitor sensed by the lock comparator.
 Assumes the bench steers reference presence and phase quality.
*/
`timescale 1ns/1ns
module pho_far_model #(
  parameter int PERIOD = 4,
  parameter int CHARGE = 8
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic refRun,
  input  wire logic lockGood,
  input  wire logic lockIndicatorPinOut,
  input  wire logic lockIndicatorPinOe,
  input  wire logic lockIndicatorPinSrc,
  output logic      pfdRefEdge,
  output logic      pfdCycle,
  output logic      phaseInLock,
  output logic      phaseOverUnlock,
  output logic      lockCmpLevel
);
  int phase;
  int charge;

  // ==========================================================
  // Phase detector events
  // ==========================================================
  // No reference means no edge at the detector at all.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase           <= 0;
      pfdRefEdge      <= 1'b0;
      pfdCycle        <= 1'b0;
      phaseInLock     <= 1'b0;
      phaseOverUnlock <= 1'b0;
    end else begin
      phase           <= (phase == PERIOD - 1) ? 0 : phase + 1;
      pfdRefEdge      <= refRun && phase == 0;
      pfdCycle        <= refRun && phase == 0;
      phaseInLock     <= refRun && phase == 0 && lockGood;
      phaseOverUnlock <= refRun && phase == 0 && !lockGood;
    end
  end

  // ==========================================================
  // Lock pin capacitor
  // ==========================================================
  // The capacitor charges from the source and empties when shorted.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      charge <= 0;
    end else if (lockIndicatorPinOe && !lockIndicatorPinOut) begin
      charge <= 0;
    end else if (lockIndicatorPinSrc && charge < CHARGE) begin
      charge <= charge + 1;
    end
  end

  assign lockCmpLevel = (charge >= CHARGE);
endmodule

// ### sim/tb.sv
/*
 Self-checking bench for the PLL holdover controller.
 Assumes the design files and the far-side model are compiled first.
*/
`timescale 1ns/1ns
`include "pho_defines.svh"
module tb;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        alignPin_n, lockCmpLevel, pfdRefEdge, pfdCycle;
  logic        phaseInLock, phaseOverUnlock, secondRefActive;
  logic        pumpOutputHiZ, bCounterReset, digitalLockFlag;
  logic        pinOut, pinOe, pinSrc, lockWindowHigh, autoSwitchEn;
  logic        preferSecondRef, vcoCalStart, refRun, lockGood;
  logic [1:0]  refBufferEn;
  int          n_errors = 0;
  int          checked = 0;
  int          cnt[4] = '{`PHO_LOCK_CNT_0, `PHO_LOCK_CNT_1,
                          `PHO_LOCK_CNT_2, `PHO_LOCK_CNT_3};

  pho_holdover_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alignPin_n(alignPin_n), .lockCmpLevel(lockCmpLevel),
    .pfdRefEdge(pfdRefEdge), .pfdCycle(pfdCycle),
    .phaseInLock(phaseInLock), .phaseOverUnlock(phaseOverUnlock),
    .secondRefActive(secondRefActive), .pumpOutputHiZ(pumpOutputHiZ),
    .bCounterReset(bCounterReset), .digitalLockFlag(digitalLockFlag),
    .lockIndicatorPinOut(pinOut), .lockIndicatorPinOe(pinOe),
    .lockIndicatorPinSrc(pinSrc), .lockWindowHigh(lockWindowHigh),
    .autoSwitchEn(autoSwitchEn), .preferSecondRef(preferSecondRef),
    .refBufferEn(refBufferEn), .vcoCalStart(vcoCalStart));

  pho_far_model far (.ref_clk(ref_clk), .rst_n(rst_n), .refRun(refRun),
    .lockGood(lockGood), .lockIndicatorPinOut(pinOut),
    .lockIndicatorPinOe(pinOe), .lockIndicatorPinSrc(pinSrc),
    .pfdRefEdge(pfdRefEdge), .pfdCycle(pfdCycle),
    .phaseInLock(phaseInLock), .phaseOverUnlock(phaseOverUnlock),
    .lockCmpLevel(lockCmpLevel));

  always #50 ref_clk = ~ref_clk;

  // ==========================================================
  // Report and compare tasks
  // ==========================================================
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic timeout(input string nm);
    $display("MISMATCH %s expected answer seen none", nm);
    n_errors++;
    summarize();
  endtask

  task automatic chk32(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  task automatic chkb(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
      n_errors++;
    end
  endtask

  // ==========================================================
  // Bus and wait tasks
  // ==========================================================
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int k;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 16) timeout("pready");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] x,
                       input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk32($sformatf("read %h", a), x, r);
    chkb("pslverr", xe, e);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Which: 0 floated pump, 1 comparator level, 2 lock flag.
  task automatic wait_until(input int which, input logic v, input int b);
    logic s;
    int   k;
    k = 0;
    do begin
      @(posedge ref_clk);
      #1;
      s = which == 0 ? pumpOutputHiZ :
          which == 1 ? lockCmpLevel : digitalLockFlag;
      k++;
    end while (s !== v && k < b);
    if (s !== v) timeout($sformatf("wait %0d", which));
  endtask

  task automatic wait_pfd(input int n);
    int k;
    int t;
    k = 0;
    t = 0;
    while (k < n && t < 2000) begin
      @(posedge ref_clk);
      t++;
      if (pfdCycle === 1'b1) k++;
    end
    if (k < n) timeout("pfd");
  endtask

  // Lock is dropped, then the reference stops once the loss is seen.
  task automatic auto_enter();
    lockGood <= 1'b0;
    wait_pfd(2);
    refRun <= 1'b0;
    wait_until(0, 1'b1, 12);
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    {ref_clk, rst_n, psel, penable, pwrite, refRun, lockGood} = '0;
    {paddr, pwdata, secondRefActive} = '0;
    alignPin_n = 1'b1;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdchk(`PHO_ADDR_LDC, 32'h0, 1'b0);
    rdchk(`PHO_ADDR_LPS, 32'h0, 1'b0);
    rdchk(`PHO_ADDR_RSC, 32'h0, 1'b0);
    rdchk(`PHO_ADDR_HOC, 32'h0, 1'b0);
    wr(8'h7c, 32'hff);
    rdchk(8'h7c, 32'h0, 1'b1);
    wr(`PHO_ADDR_LPS, 32'hff);
    rdchk(`PHO_ADDR_LPS, 32'h3f, 1'b0);
    wr(`PHO_ADDR_RSC, 32'h16);
    settle(2);
    chkb("autoSwitchEn", 1'b1, autoSwitchEn);
    chkb("preferSecondRef", 1'b0, preferSecondRef);
    chk32("refBufferEn", 32'h3, 32'(refBufferEn));
    wr(`PHO_ADDR_RSC, 32'h08);
    settle(2);
    chkb("preferSecondRef", 1'b1, preferSecondRef);
    refRun <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(`PHO_ADDR_LDC, 32'(i << 5));
      lockGood <= 1'b0;
      wait_pfd(2);
      lockGood <= 1'b1;
      #1;
      chkb("lock flag", 1'b0, digitalLockFlag);
      wait_pfd(cnt[i] - 1);
      #1;
      chkb("lock flag", 1'b0, digitalLockFlag);
      wait_pfd(1);
      #1;
      chkb("lock flag", 1'b1, digitalLockFlag);
    end
    chkb("lockWindowHigh", 1'b1, lockWindowHigh);
    wr(`PHO_ADDR_LPS, 32'h01);
    settle(2);
    chk32("pin logic", 32'h3, {29'h0, pinSrc, pinOe, pinOut});
    wr(`PHO_ADDR_LDC, 32'h10);
    settle(2);
    chkb("lockWindowHigh", 1'b0, lockWindowHigh);
    wr(`PHO_ADDR_LDC, 32'h01);
    settle(2);
    chkb("vcoCalStart", 1'b1, vcoCalStart);
    wr(`PHO_ADDR_LDC, 32'h00);
    // Manual mode, no reference; channel dividers are off-block.
    refRun <= 1'b0;
    alignPin_n <= 1'b0;
    wr(`PHO_ADDR_HOC, 32'h07);
    settle(10);
    chkb("held low pin", 1'b0, pumpOutputHiZ);
    foreach (cnt[i]) begin
      if (i < 2) begin
        wr(`PHO_ADDR_HOC, i == 0 ? 32'h03 : 32'h06);
        alignPin_n <= 1'b1;
        settle(4);
        alignPin_n <= 1'b0;
        settle(10);
        chkb("one enable only", 1'b0, pumpOutputHiZ);
      end
    end
    alignPin_n <= 1'b1;
    wr(`PHO_ADDR_HOC, 32'h07);
    settle(4);
    alignPin_n <= 1'b0;
    wait_until(0, 1'b1, 8);
    alignPin_n <= 1'b1;
    settle(20);
    chkb("no reference", 1'b1, pumpOutputHiZ);
    refRun <= 1'b1;
    wait_until(0, 1'b0, 12);
    chkb("bCounterReset", 1'b1, bCounterReset);
    settle(1);
    chkb("bCounterReset", 1'b0, bCounterReset);
    // Automatic mode on the current-source lock pin.
    secondRefActive <= 1'b1;
    wr(`PHO_ADDR_LPS, 32'h04);
    lockGood <= 1'b1;
    wait_until(1, 1'b1, 400);
    chkb("pin source", 1'b1, pinSrc);
    wr(`PHO_ADDR_HOC, 32'h05);
    lockGood <= 1'b0;
    wait_until(2, 1'b0, 20);
    settle(1);
    chk32("pin shorted", 32'h2, {29'h0, pinSrc, pinOe, pinOut});
    settle(10);
    chkb("comparator off", 1'b0, pumpOutputHiZ);
    lockGood <= 1'b1;
    wait_until(1, 1'b1, 400);
    wr(`PHO_ADDR_HOC, 32'h0d);
    auto_enter();
    settle(20);
    chkb("no reference", 1'b1, pumpOutputHiZ);
    rdchk(`PHO_ADDR_STS, 32'h51, 1'b0);
    refRun <= 1'b1;
    wait_until(0, 1'b0, 12);
    chkb("bCounterReset", 1'b1, bCounterReset);
    settle(20);
    chkb("rearm", 1'b0, pumpOutputHiZ);
    rdchk(`PHO_ADDR_STS, 32'h70, 1'b0);
    lockGood <= 1'b1;
    wait_until(1, 1'b1, 400);
    settle(4);
    auto_enter();
    wr(`PHO_ADDR_HOC, 32'h00);
    wait_until(0, 1'b0, 4);
    chkb("no counter reset", 1'b0, bCounterReset);
    summarize();
  end
endmodule
